/* File: rtl/spi_stream_regs.vh */
`ifndef SPI_STREAM_REGS_VH
`define SPI_STREAM_REGS_VH

// ****************************************************************
// addresses of the registers held inside the access logic
// ****************************************************************
`define ADDR_CFG_A        7'h00
`define ADDR_CFG_B        7'h01
`define ADDR_STREAM_LEN   7'h0e
`define ADDR_XFER         7'h0f
`define ADDR_CFG_C        7'h10
`define ADDR_STATUS       7'h11

// ****************************************************************
// field positions
// ****************************************************************
`define BIT_ADDR_ASC      0
`define BIT_SINGLE_INSTR  0
`define BIT_KEEP_LEN      0
`define BIT_SHORT_BYTE    0
`define BIT_CRC_INVALID   1

// ****************************************************************
// reset values
// ****************************************************************
`define RST_ADDR_ASC      1'b0
`define RST_SINGLE_INSTR  1'b0
`define RST_KEEP_LEN      1'b0
`define RST_STREAM_LEN    8'h00
`define RST_CRC_EN        2'b00

// ****************************************************************
// address space, crc and field codes
// ****************************************************************
`define ADDR_BOTTOM       7'h00
`define ADDR_TOP          7'h4b
`define ADDR_WIDE_MIN     7'h29
`define CRC_SEED          8'ha5
`define CRC_POLY          8'h07
`define CRC_EN_ON         2'b01
`define CRC_EN_OFF        2'b00

`endif

/* File: rtl/crc8_serial.v */
`timescale 1ns/1ns

// ****************************************************************
// bit-serial crc-8, msb first, no final inversion
// ****************************************************************
module crc8_serial (
  input  wire       clock,    // system clock
  input  wire       sys_rst,  // synchronous reset
  input  wire       init,     // load seed
  input  wire [7:0] seed,     // seed value
  input  wire       bit_en,   // shift one bit in
  input  wire       bit_in,   // serial data bit
  output reg  [7:0] crc_reg   // running code
);

`include "spi_stream_regs.vh"

  wire fb;

  assign fb = crc_reg[7] ^ bit_in;

  // init wins over a shift in the same cycle
  always @(posedge clock) begin
    if (sys_rst) begin
      crc_reg <= `CRC_SEED;
    end else if (init) begin
      crc_reg <= seed;
    end else if (bit_en) begin
      crc_reg <= {crc_reg[6:0], 1'b0} ^ (fb ? `CRC_POLY : 8'h00);
    end
  end

endmodule // crc8_serial

/* File: rtl/spi_stream_access.v */
`timescale 1ns/1ns

module spi_stream_access (
  input  wire        clock,            // system clock, 50 mhz
  input  wire        sys_rst,          // synchronous reset, active high
  input  wire        sclk,             // serial clock pin
  input  wire        cs_n,             // chip select pin, active low
  input  wire        sdi,              // serial data in pin
  output reg         sdo_reg,          // serial data out pin
  output reg  [6:0]  rd_addr_reg,      // read address to register file
  input  wire [7:0]  rd_data,          // register file read data
  output reg         wr_strobe_reg,    // one-cycle write commit
  output reg  [6:0]  wr_addr_reg,      // lowest address of write unit
  output reg  [15:0] wr_data_reg,      // [7:0] at wr_addr, [15:8] above
  output reg         wr_len_reg,       // 0 one byte, 1 two bytes
  output reg         addr_asc_reg,     // address direction, 1 ascending
  output reg         single_instr_reg, // single instruction mode
  output reg         keep_len_reg,     // keep loop length at frame end
  output reg  [7:0]  stream_len_reg,   // loop length in bytes
  output reg         crc_on_reg,       // crc checking active
  output reg         crc_invalid_reg,  // invalid or missing crc flag
  output reg         short_byte_flag   // clock count error flag
);

`include "spi_stream_regs.vh"

  // ****************************************************************
  // pin synchronisers and edge detection
  // ****************************************************************
  localparam PH_IDLE  = 4'b0001;
  localparam PH_INSTR = 4'b0010;
  localparam PH_DATA  = 4'b0100;
  localparam PH_CRC   = 4'b1000;

  reg  [2:0] sclk_sync_reg;
  reg  [2:0] cs_sync_reg;
  reg  [1:0] sdi_sync_reg;
  wire       sclk_rise;
  wire       sclk_fall;
  wire       cs_fall;
  wire       cs_rise;
  wire       cs_active;
  wire       sdi_s;

  // the first stage of each chain feeds only the second
  always @(posedge clock) begin
    if (sys_rst) begin
      sclk_sync_reg <= 3'h0;
      cs_sync_reg   <= 3'h7;
      sdi_sync_reg  <= 2'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk};
      cs_sync_reg   <= {cs_sync_reg[1:0], cs_n};
      sdi_sync_reg  <= {sdi_sync_reg[0], sdi};
    end
  end

  assign cs_active = ~cs_sync_reg[1];
  assign cs_fall   = ~cs_sync_reg[1] & cs_sync_reg[2];
  assign cs_rise   = cs_sync_reg[1] & ~cs_sync_reg[2];
  assign sclk_rise = cs_active & sclk_sync_reg[1] & ~sclk_sync_reg[2];
  assign sclk_fall = cs_active & ~sclk_sync_reg[1] & sclk_sync_reg[2];
  assign sdi_s     = sdi_sync_reg[1];

  // ****************************************************************
  // frame state
  // ****************************************************************
  reg  [3:0]  phase_reg;
  reg  [2:0]  bit_cnt_reg;
  reg  [7:0]  rx_sh_reg;
  reg  [7:0]  tx_sh_reg;
  reg         load_pend_reg;
  reg         rw_reg;
  reg  [6:0]  addr_reg;
  reg  [6:0]  start_addr_reg;
  reg  [7:0]  loop_cnt_reg;
  reg         unit_idx_reg;
  reg         unit_wide_reg;
  reg  [6:0]  unit_addr_reg;
  reg  [7:0]  first_byte_reg;
  reg         commit_go_reg;
  reg         crc_bad_reg;
  reg         short_reg;
  wire [7:0]  crc_val;
  wire [7:0]  rx_byte;
  wire        byte_end;
  wire        crc_feed;
  wire        crc_bit;
  wire        crc_init;
  wire [7:0]  crc_seed;
  wire        wide_now;
  wire        loop_hit;
  reg  [6:0]  addr_next;
  reg  [7:0]  rd_mux;

  assign rx_byte  = {rx_sh_reg[6:0], sdi_s};
  assign byte_end = sclk_rise & (bit_cnt_reg == 3'h7);
  assign wide_now = (addr_reg >= `ADDR_WIDE_MIN);
  assign loop_hit = (stream_len_reg != 8'h00) && (loop_cnt_reg + 8'h01 == stream_len_reg);

  // crc runs over instruction and data bits, never over its own byte
  assign crc_feed = sclk_rise & (phase_reg == PH_INSTR || phase_reg == PH_DATA);
  assign crc_bit  = (phase_reg == PH_DATA && rw_reg) ? tx_sh_reg[7] : sdi_s;
  assign crc_init = cs_fall | (byte_end & (phase_reg == PH_CRC));
  // first code of a frame and single mode use the fixed seed
  assign crc_seed = (cs_fall | single_instr_reg) ? `CRC_SEED : {1'b0, addr_reg};

  crc8_serial u_crc (
    .clock   (clock),
    .sys_rst (sys_rst),
    .init    (crc_init),
    .seed    (crc_seed),
    .bit_en  (crc_feed),
    .bit_in  (crc_bit),
    .crc_reg (crc_val)
  );

  // next address: loop back, else step with wraparound
  always @* begin
    if (loop_hit) begin
      addr_next = start_addr_reg;
    end else if (addr_asc_reg) begin
      addr_next = (addr_reg == `ADDR_TOP) ? `ADDR_BOTTOM : addr_reg + 7'h01;
    end else begin
      addr_next = (addr_reg == `ADDR_BOTTOM) ? `ADDR_TOP : addr_reg - 7'h01;
    end
  end

  // read data, internal registers answered locally
  always @* begin
    case (rd_addr_reg)
      `ADDR_CFG_A:      rd_mux = {7'h00, addr_asc_reg};
      `ADDR_CFG_B:      rd_mux = {7'h00, single_instr_reg};
      `ADDR_STREAM_LEN: rd_mux = stream_len_reg;
      `ADDR_XFER:       rd_mux = {7'h00, keep_len_reg};
      `ADDR_CFG_C:      rd_mux = {4'h0, 1'b1, ~crc_on_reg, 1'b0, crc_on_reg};
      `ADDR_STATUS:     rd_mux = {6'h00, crc_invalid_reg, short_byte_flag};
      default:          rd_mux = rd_data;
    endcase
  end

  // ****************************************************************
  // serial engine
  // ****************************************************************
  always @(posedge clock) begin
    if (sys_rst) begin
      phase_reg      <= PH_IDLE;
      bit_cnt_reg    <= 3'h0;
      rx_sh_reg      <= 8'h00;
      tx_sh_reg      <= 8'h00;
      load_pend_reg  <= 1'b0;
      rw_reg         <= 1'b0;
      addr_reg       <= 7'h00;
      start_addr_reg <= 7'h00;
      loop_cnt_reg   <= 8'h00;
      unit_idx_reg   <= 1'b0;
      unit_wide_reg  <= 1'b0;
      unit_addr_reg  <= 7'h00;
      first_byte_reg <= 8'h00;
      commit_go_reg  <= 1'b0;
      crc_bad_reg    <= 1'b0;
      short_reg      <= 1'b0;
      rd_addr_reg    <= 7'h00;
      sdo_reg        <= 1'b0;
      wr_strobe_reg  <= 1'b0;
      wr_addr_reg    <= 7'h00;
      wr_data_reg    <= 16'h0000;
      wr_len_reg     <= 1'b0;
    end else begin
      commit_go_reg <= 1'b0;
      crc_bad_reg   <= 1'b0;
      short_reg     <= 1'b0;
      wr_strobe_reg <= commit_go_reg;
      sdo_reg       <= tx_sh_reg[7];
      if (cs_fall) begin
        phase_reg     <= PH_INSTR;
        bit_cnt_reg   <= 3'h0;
        tx_sh_reg     <= 8'h00;
        load_pend_reg <= 1'b0;
      end else if (cs_rise) begin
        phase_reg <= PH_IDLE;
        // a half-received byte never reaches a register
        if (phase_reg == PH_DATA && !rw_reg && bit_cnt_reg != 3'h0) begin
          short_reg <= 1'b1;
        end
        // an unfinished checked write counts as a missing code
        if (crc_on_reg && !rw_reg && (phase_reg == PH_CRC ||
            (phase_reg == PH_DATA && (unit_idx_reg || bit_cnt_reg != 3'h0)))) begin
          crc_bad_reg <= 1'b1;
        end
      end else begin
        if (sclk_fall) begin
          if (load_pend_reg) begin
            tx_sh_reg     <= (phase_reg == PH_CRC) ? crc_val : rd_mux;
            load_pend_reg <= 1'b0;
          end else begin
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
          end
        end
        if (sclk_rise) begin
          rx_sh_reg   <= rx_byte;
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
        if (byte_end) begin
          load_pend_reg <= 1'b1;
          case (phase_reg)
            PH_INSTR: begin
              rw_reg         <= rx_byte[7];
              addr_reg       <= rx_byte[6:0];
              start_addr_reg <= rx_byte[6:0];
              rd_addr_reg    <= rx_byte[6:0];
              loop_cnt_reg   <= 8'h00;
              unit_idx_reg   <= 1'b0;
              phase_reg      <= PH_DATA;
            end
            PH_DATA: begin
              addr_reg     <= addr_next;
              rd_addr_reg  <= addr_next;
              loop_cnt_reg <= loop_hit ? 8'h00 : loop_cnt_reg + 8'h01;
              if (!unit_idx_reg) begin
                unit_addr_reg  <= addr_reg;
                unit_wide_reg  <= wide_now;
                first_byte_reg <= rx_byte;
              end
              if (!unit_idx_reg && wide_now) begin
                unit_idx_reg <= 1'b1; // wait for the second byte
              end else begin
                unit_idx_reg <= 1'b0;
                // assemble the unit as a little-endian word
                if (!unit_idx_reg) begin
                  wr_addr_reg <= addr_reg;
                  wr_data_reg <= {8'h00, rx_byte};
                  wr_len_reg  <= 1'b0;
                end else if (addr_asc_reg) begin
                  wr_addr_reg <= unit_addr_reg;
                  wr_data_reg <= {rx_byte, first_byte_reg};
                  wr_len_reg  <= 1'b1;
                end else begin
                  wr_addr_reg <= addr_reg;
                  wr_data_reg <= {first_byte_reg, rx_byte};
                  wr_len_reg  <= 1'b1;
                end
                if (crc_on_reg) begin
                  phase_reg    <= PH_CRC;
                end else begin
                  commit_go_reg <= !rw_reg && !(unit_idx_reg && addr_asc_reg);
                  phase_reg     <= single_instr_reg ? PH_INSTR : PH_DATA;
                end
              end
            end
            PH_CRC: begin
              if (!rw_reg) begin
                // last data bit lands in the code on the byte end edge,
                // and the code stays frozen through the check byte
                if (rx_byte == crc_val) begin
                  commit_go_reg <= !(unit_wide_reg && addr_asc_reg);
                end else begin
                  crc_bad_reg <= 1'b1;
                end
              end
              phase_reg <= single_instr_reg ? PH_INSTR : PH_DATA;
            end
            default: begin
              phase_reg <= PH_IDLE;
            end
          endcase
        end
      end
    end
  end

  // ****************************************************************
  // internal registers and flags
  // ****************************************************************
  wire       cfg_c_hit;
  wire [1:0] en_field;
  wire [1:0] en_b_field;

  assign cfg_c_hit  = commit_go_reg && (wr_addr_reg == `ADDR_CFG_C) && !wr_len_reg;
  assign en_field   = wr_data_reg[1:0];
  assign en_b_field = wr_data_reg[3:2];

  // commits seen here already passed the crc check when it is on
  always @(posedge clock) begin
    if (sys_rst) begin
      addr_asc_reg     <= `RST_ADDR_ASC;
      single_instr_reg <= `RST_SINGLE_INSTR;
      keep_len_reg     <= `RST_KEEP_LEN;
      stream_len_reg   <= `RST_STREAM_LEN;
      crc_on_reg       <= 1'b0;
      crc_invalid_reg  <= 1'b0;
      short_byte_flag  <= 1'b0;
    end else begin
      if (commit_go_reg && !wr_len_reg) begin
        case (wr_addr_reg)
          `ADDR_CFG_A: addr_asc_reg     <= wr_data_reg[`BIT_ADDR_ASC];
          `ADDR_CFG_B: single_instr_reg <= wr_data_reg[`BIT_SINGLE_INSTR];
          `ADDR_XFER:  keep_len_reg     <= wr_data_reg[`BIT_KEEP_LEN];
          default:     addr_asc_reg     <= addr_asc_reg;
        endcase
      end
      if (cfg_c_hit && en_b_field == ~en_field) begin
        if (en_field == `CRC_EN_ON) begin
          crc_on_reg <= 1'b1;
        end else if (en_field == `CRC_EN_OFF) begin
          crc_on_reg <= 1'b0;
        end
      end
      // frame end autoreset beats a write in the same cycle
      if (cs_rise && !keep_len_reg) begin
        stream_len_reg <= 8'h00;
      end else if (commit_go_reg && !wr_len_reg && wr_addr_reg == `ADDR_STREAM_LEN) begin
        stream_len_reg <= wr_data_reg[7:0];
      end
      // set wins over a clear in the same cycle
      if (crc_bad_reg) begin
        crc_invalid_reg <= 1'b1;
      end else if (commit_go_reg && !wr_len_reg && wr_addr_reg == `ADDR_STATUS &&
                   wr_data_reg[`BIT_CRC_INVALID]) begin
        crc_invalid_reg <= 1'b0;
      end
      if (short_reg) begin
        short_byte_flag <= 1'b1;
      end else if (commit_go_reg && !wr_len_reg && wr_addr_reg == `ADDR_STATUS &&
                   wr_data_reg[`BIT_SHORT_BYTE]) begin
        short_byte_flag <= 1'b0;
      end
    end
  end

endmodule // spi_stream_access

/* File: dv/spi_stream_monitor.sv */
`timescale 1ns/1ns
`include "spi_stream_regs.vh"

// ********************
// port checker
// ********************
module spi_stream_monitor (
  input wire         clock,            // clock
  input wire         sys_rst,          // reset
  input wire         cs_n,             // select pin
  input logic        wr_strobe_reg,    // commit
  input logic [6:0]  wr_addr_reg,      // commit address
  input logic [15:0] wr_data_reg,      // commit data
  input logic        wr_len_reg,       // commit width
  input logic        addr_asc_reg,     // direction
  input logic        single_instr_reg, // single mode
  input logic        keep_len_reg,     // keep length
  input logic [7:0]  stream_len_reg,   // loop length
  input logic        crc_on_reg,       // crc on
  input logic        crc_invalid_reg,  // crc flag
  input logic        short_byte_flag   // short flag
);
  default clocking mon_cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // frame end, split by the keep bit seen at select rise
  sequence frame_end_s(kept);
    $rose(cs_n) && keep_len_reg == kept;
  endsequence

  // control state after reset release
  reset_state_a: assert property ($fell(sys_rst) |-> !addr_asc_reg && !single_instr_reg
    && !crc_on_reg && stream_len_reg == 8'h00) else $error("state not cleared by reset");
  unkept_clear_a: assert property (frame_end_s(1'b0) |-> ##[1:6] stream_len_reg == 8'h00)
    else $error("loop length not cleared at frame end");
  kept_length_a: assert property (frame_end_s(1'b1) |=> $stable(stream_len_reg) [*6])
    else $error("kept loop length changed");
  len_source_a: assert property ($changed(stream_len_reg) |-> cs_n ||
    (wr_addr_reg == `ADDR_STREAM_LEN && stream_len_reg == wr_data_reg[7:0]))
    else $error("loop length changed without a write");
  crc_switch_a: assert property ($changed(crc_on_reg) |-> wr_addr_reg == `ADDR_CFG_C &&
    (wr_data_reg[3:0] == 4'h9 || wr_data_reg[3:0] == 4'hc)) else $error("crc enable moved");
  invalid_set_a: assert property ($rose(crc_invalid_reg) |-> crc_on_reg &&
    !wr_strobe_reg && !$past(wr_strobe_reg)) else $error("crc flag set beside a commit");
  invalid_clear_a: assert property ($fell(crc_invalid_reg) |->
    wr_addr_reg == `ADDR_STATUS && wr_data_reg[1]) else $error("crc flag cleared unasked");
  wide_desc_a: assert property (wr_strobe_reg && wr_addr_reg >= `ADDR_WIDE_MIN |->
    !addr_asc_reg && wr_len_reg) else $error("wide commit while ascending");
  short_flag_a: assert property ($rose(short_byte_flag) |-> cs_n && !wr_strobe_reg)
    else $error("short flag outside frame end");
  single_mode_a: assert property ($changed(single_instr_reg) |->
    wr_addr_reg == `ADDR_CFG_B) else $error("mode changed without a write");
endmodule // spi_stream_monitor

/* File: dv/spi_host_model.sv */
`timescale 1ns/1ns

// ********************
// host master, mode 0
// ********************
module spi_host_model (
  output logic sclk,  // serial clock
  output logic cs_n,  // select
  output logic sdi,   // data to device
  input  wire  sdo    // data from device
);
  logic framed;

  // idle values, select released
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
    framed = 1'b0;
  end

  // stale idle data would hide a missed bit, so it toggles
  always #80 begin
    if (!framed) sdi = ~sdi;
  end

  // select low, then one idle period before the first edge
  task automatic start();
    framed = 1'b1;
    #7 cs_n = 1'b0;
    #160;
  endtask

  // msb first, data held over the rise, sdo taken at the fall
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      sdi = tx[i];
      #80 sclk = 1'b1;
      #80 rx[i] = sdo;
      sclk = 1'b0;
    end
  endtask

  // the byte count ends with the select rising
  task automatic stop();
    #400 cs_n = 1'b1;
    framed = 1'b0;
    #400;
  endtask
endmodule // spi_host_model

/* File: dv/test_spi_stream_access.sv */
`timescale 1ns/1ns
`include "spi_stream_regs.vh"

module test_spi_stream_access;
  logic        clock, sys_rst;
  wire         sclk, cs_n, sdi, sdo_reg, wr_strobe_reg, wr_len_reg, addr_asc_reg;
  wire         single_instr_reg, keep_len_reg, crc_on_reg, crc_invalid_reg, short_byte_flag;
  wire  [6:0]  rd_addr_reg, wr_addr_reg;
  wire  [7:0]  rd_data, stream_len_reg;
  wire  [15:0] wr_data_reg;
  int          fail_count, tests_run, seed, n;
  logic [7:0]  rx, d, d_hi;
  logic [23:0] seen_q[$], exp_q[$];

  spi_stream_access u_dut (.clock(clock), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi), .sdo_reg(sdo_reg), .rd_addr_reg(rd_addr_reg), .rd_data(rd_data),
    .wr_strobe_reg(wr_strobe_reg), .wr_addr_reg(wr_addr_reg), .wr_data_reg(wr_data_reg),
    .wr_len_reg(wr_len_reg), .addr_asc_reg(addr_asc_reg), .single_instr_reg(single_instr_reg),
    .keep_len_reg(keep_len_reg), .stream_len_reg(stream_len_reg), .crc_on_reg(crc_on_reg),
    .crc_invalid_reg(crc_invalid_reg), .short_byte_flag(short_byte_flag));
  spi_host_model u_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_reg));

  // register file stand-in and commit log
  assign rd_data = {1'b0, rd_addr_reg} ^ 8'h5a;
  always #10 clock = ~clock;
  always @(posedge clock) begin
    if (wr_strobe_reg === 1'b1) seen_q.push_back({wr_len_reg, wr_addr_reg, wr_data_reg});
  end

  // ********************
  // helpers
  // ********************
  task automatic check(input logic [23:0] seen, input logic [23:0] expd);
    tests_run++;
    if (seen !== expd) begin
      fail_count++;
      $display("Error %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask

  task automatic summarize();
    if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // serial crc-8, msb first, no final inversion
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? `CRC_POLY : 8'h00);
    return c;
  endfunction

  task automatic check_commits();
    check(24'(seen_q.size()), 24'(exp_q.size()));
    while (seen_q.size() > 0 && exp_q.size() > 0) check(seen_q.pop_front(), exp_q.pop_front());
    seen_q.delete();
    exp_q.delete();
  endtask

  task automatic put(input logic [7:0] b);
    u_host.xfer(b, 8, rx);
  endtask

  task automatic frame_start();
    @(posedge clock);
    #1 u_host.start();
  endtask

  // one byte write; mode 0 no crc, 1 good crc, 2 corrupted crc
  task automatic wr1(input logic [6:0] a, input logic [7:0] b, input int mode, input bit ok);
    logic [7:0] c;
    c = crc8(crc8(`CRC_SEED, {1'b0, a}), b);
    frame_start();
    put({1'b0, a});
    put(b);
    if (mode > 0) put(mode == 1 ? c : ~c);
    if (mode > 0) check({16'h0, rx}, {16'h0, c});
    u_host.stop();
    if (ok) exp_q.push_back({1'b0, a, 8'h00, b});
    check_commits();
  endtask

  // ********************
  // main sequence
  // ********************
  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    seed = 2636;
    fail_count = 0;
    tests_run = 0;
    repeat (5) @(posedge clock);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge clock);
    check({11'h0, addr_asc_reg, single_instr_reg, keep_len_reg, crc_on_reg, crc_invalid_reg,
      stream_len_reg}, 24'h0);
    // descending stream from 0x01 runs through 0x00 into the top wide pair
    frame_start();
    put(8'h01);
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      if (i < 2) d[0] = 1'b0;
      put(d);
      if (i < 2) exp_q.push_back({1'b0, 7'(1 - i), 8'h00, d});
      if (i == 2) d_hi = d;
      if (i == 3) exp_q.push_back({1'b1, 7'h4a, d_hi, d});
    end
    u_host.stop();
    check_commits();
    // ascending from the top wide pair: dropped, then wraps to 0x00
    wr1(7'h00, 8'h01, 0, 1'b1);
    check({23'h0, addr_asc_reg}, 24'h1);
    frame_start();
    put(8'h4a);
    put(8'($random(seed)));
    put(8'($random(seed)));
    put(8'h01);
    d = 8'($random(seed)) & 8'hfe;
    put(d);
    exp_q.push_back({1'b0, 7'h00, 16'h0001});
    exp_q.push_back({1'b0, 7'h01, 8'h00, d});
    u_host.stop();
    check_commits();
    // loop length: cleared at frame end, then kept, then looping
    wr1(7'h0e, 8'h03, 0, 1'b1);
    check({16'h0, stream_len_reg}, 24'h0);
    wr1(7'h0f, 8'h01, 0, 1'b1);
    wr1(7'h0e, 8'h02, 0, 1'b1);
    check({16'h0, stream_len_reg}, 24'h2);
    frame_start();
    put(8'h20);
    for (int i = 0; i < 5; i++) begin
      d = 8'($random(seed));
      put(d);
      exp_q.push_back({1'b0, 7'h20 + 7'(i % 2), 8'h00, d});
    end
    u_host.stop();
    check_commits();
    wr1(7'h0f, 8'h00, 0, 1'b1);
    check({16'h0, stream_len_reg}, 24'h0);
    // data byte cut short after five bits
    frame_start();
    put(8'h25);
    u_host.xfer(8'h3c, 5, rx);
    u_host.stop();
    for (n = 0; n < 40 && short_byte_flag !== 1'b1; n++)
      @(posedge clock);
    check({23'h0, short_byte_flag}, 24'h1);
    check_commits();
    // crc enable handshake, checked writes, flag set and clear
    wr1(7'h10, 8'h05, 0, 1'b1);
    check({23'h0, crc_on_reg}, 24'h0);
    wr1(7'h10, 8'h09, 0, 1'b1);
    check({23'h0, crc_on_reg}, 24'h1);
    d = 8'($random(seed));
    wr1(7'h22, d, 1, 1'b1);
    wr1(7'h23, d, 2, 1'b0);
    check({23'h0, crc_invalid_reg}, 24'h1);
    wr1(7'h11, 8'h02, 2, 1'b0);
    check({23'h0, crc_invalid_reg}, 24'h1);
    wr1(7'h11, 8'h02, 1, 1'b1);
    check({23'h0, crc_invalid_reg}, 24'h0);
    wr1(7'h24, d, 0, 1'b0);
    check({23'h0, crc_invalid_reg}, 24'h1);
    // streamed checked units: later seed is the next unit's address byte
    frame_start();
    put(8'h26);
    for (int i = 0; i < 2; i++) begin
      d = 8'($random(seed));
      put(d);
      put(crc8(i == 0 ? crc8(`CRC_SEED, 8'h26) : 8'h27, d));
      exp_q.push_back({1'b0, 7'h26 + 7'(i), 8'h00, d});
    end
    u_host.stop();
    check_commits();
    // checked read: device code covers the returned data
    frame_start();
    put(8'ha0);
    put(8'h00);
    check({16'h0, rx}, 24'h00007a);
    put(crc8(crc8(`CRC_SEED, 8'ha0), 8'h00));
    check({16'h0, rx}, {16'h0, crc8(crc8(`CRC_SEED, 8'ha0), 8'h7a)});
    u_host.stop();
    wr1(7'h10, 8'h0c, 1, 1'b1);
    check({23'h0, crc_on_reg}, 24'h0);
    // single instruction: every unit is followed by a fresh instruction
    wr1(7'h01, 8'h01, 0, 1'b1);
    check({23'h0, single_instr_reg}, 24'h1);
    frame_start();
    for (int i = 0; i < 2; i++) begin
      d = 8'($random(seed));
      put({1'b0, (i == 0) ? 7'h23 : 7'h05});
      put(d);
      exp_q.push_back({1'b0, (i == 0) ? 7'h23 : 7'h05, 8'h00, d});
    end
    u_host.stop();
    check_commits();
    summarize();
  end
endmodule // test_spi_stream_access

bind spi_stream_access spi_stream_monitor u_mon (.clock(clock), .sys_rst(sys_rst),
  .cs_n(cs_n), .wr_strobe_reg(wr_strobe_reg), .wr_addr_reg(wr_addr_reg),
  .wr_data_reg(wr_data_reg), .wr_len_reg(wr_len_reg), .addr_asc_reg(addr_asc_reg),
  .single_instr_reg(single_instr_reg), .keep_len_reg(keep_len_reg),
  .stream_len_reg(stream_len_reg), .crc_on_reg(crc_on_reg),
  .crc_invalid_reg(crc_invalid_reg), .short_byte_flag(short_byte_flag));
